// File: inc/sbtrc_pkg.sv
/*
 * Constants for the sixteen-bit reload/capture timer: register offsets,
 * field positions, reset values, mode codes and the cycle-clock divider.
 * Assumes a single 200 MHz clock and an 8-bit register port.
 */
`default_nettype none

package sbtrc_pkg;

    // ==========================================================
    // register port shape
    localparam int SBTRC_ADDR_W = 3;
    localparam int SBTRC_DATA_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [2:0] SBTRC_OFS_CNT_LO  = 3'h0;
    localparam logic [2:0] SBTRC_OFS_CNT_HI  = 3'h1;
    localparam logic [2:0] SBTRC_OFS_RLD_LO  = 3'h2;
    localparam logic [2:0] SBTRC_OFS_RLD_HI  = 3'h3;
    localparam logic [2:0] SBTRC_OFS_CTRL    = 3'h4;
    localparam logic [2:0] SBTRC_OFS_STATUS  = 3'h5;
    localparam logic [2:0] SBTRC_OFS_MASK    = 3'h6;
    localparam logic [2:0] SBTRC_OFS_PIN     = 3'h7;

    // ==========================================================
    // field positions
    localparam int SBTRC_CTRL_MODE_HI = 7;
    localparam int SBTRC_CTRL_MODE_LO = 5;
    localparam int SBTRC_CTRL_RUN     = 4;
    localparam int SBTRC_STAT_UF      = 0;
    localparam int SBTRC_STAT_CAP     = 1;
    localparam int SBTRC_NUM_EVT      = 2;
    localparam int SBTRC_PIN_LEVEL    = 0;
    localparam int SBTRC_PIN_INPUT    = 1;

    // ==========================================================
    // reset values
    localparam logic [15:0] SBTRC_CNT_RST  = 16'h0000;
    localparam logic [15:0] SBTRC_RLD_RST  = 16'h0000;
    localparam logic [2:0]  SBTRC_MODE_RST = 3'h0;
    localparam logic        SBTRC_RUN_RST  = 1'b0;
    localparam logic [1:0]  SBTRC_EVT_RST  = 2'h0;
    localparam logic        SBTRC_PIN_RST  = 1'b0;

    // ==========================================================
    // mode codes
    localparam logic [2:0] SBTRC_MODE_EVT_RISE = 3'h0;
    localparam logic [2:0] SBTRC_MODE_EVT_FALL = 3'h1;
    localparam logic [2:0] SBTRC_MODE_BAD_A    = 3'h2;
    localparam logic [2:0] SBTRC_MODE_BAD_B    = 3'h3;
    localparam logic [2:0] SBTRC_MODE_TIMER    = 3'h4;
    localparam logic [2:0] SBTRC_MODE_TOGGLE   = 3'h5;
    localparam logic [2:0] SBTRC_MODE_CAP_RISE = 3'h6;
    localparam logic [2:0] SBTRC_MODE_CAP_FALL = 3'h7;

    // ==========================================================
    // instruction cycle clock
    localparam int SBTRC_OSC_PERIOD_NS = 5;
    localparam int SBTRC_TC_DIV        = 10;
    localparam int SBTRC_TC_PERIOD_NS  = SBTRC_TC_DIV * SBTRC_OSC_PERIOD_NS;
    localparam int SBTRC_TC_CYCLES     =
        SBTRC_TC_PERIOD_NS / SBTRC_OSC_PERIOD_NS;
    localparam logic [3:0] SBTRC_TC_LAST   = 4'(SBTRC_TC_CYCLES - 1);
    localparam logic [3:0] SBTRC_PRESC_RST = 4'h0;

endpackage

`default_nettype wire

// File: verilog/sbtrc_timer.sv
/*
 * Sixteen-bit down counter with a reload/capture register, a divide-by-ten
 * cycle prescaler, a timer pin that may be driven, and a masked interrupt.
 * Assumes the register master and the pin are synchronous to clk.
 */
// The address map and the strobed register port were decided locally.
`default_nettype none

// Notes on behaviour
// RQ1: counter and reload register as byte halves
// RQ2: control bits 7..5 choose mode; 010/011 barred
// RQ3: run bit starts and stops the counter
// RQ4: timer modes count cycles, reload on underflow
// RQ5: underflow raises interrupt in reload modes
// RQ6: mode 101 inverts the pin on underflow
// RQ7: event mode counts chosen pin edge, reloads
// RQ8: capture mode copies counter on pin edge
// RQ9: capture edge choice; interrupt on that edge
// RQ10: software presets pin high and both times
// RQ11: software alternates on/off times per interrupt
// RQ12: cycle clock is oscillator divided by ten
// RQ13: stopped counter holds; no events happen
module sbtrc_timer
    import sbtrc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register port
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output var  logic [7:0]  rd_data,
    // timer pin
    input  wire logic        timer_io_pin_in,
    output var  logic        timer_io_pin_out,
    output var  logic        timer_io_pin_oe_b,
    // interrupt
    output var  logic        irq
);

    // ==========================================================
    // decode helpers
    function automatic logic is_tc_mode(input logic [2:0] m);
        return m[2];
    endfunction

    function automatic logic is_cap_mode(input logic [2:0] m);
        return m[2] & m[1];
    endfunction

    function automatic logic edge_hit(input logic [2:0] m,
                                      input logic       rise,
                                      input logic       fall);
        return m[0] ? fall : rise;
    endfunction

    function automatic logic reg_wr(input logic [2:0] a,
                                    input logic       stb,
                                    input logic [2:0] ofs);
        return stb && (a == ofs);
    endfunction

    // ==========================================================
    // state
    logic [3:0]  presc;
    logic [3:0]  next_presc;
    logic        pin_prev;
    logic        next_pin_prev;
    logic [15:0] main_down_counter;
    logic [15:0] next_main_down_counter;
    logic [15:0] reload_capture_reg;
    logic [15:0] next_reload_capture_reg;
    logic [2:0]  mode;
    logic [2:0]  next_mode;
    logic        counter_run_bit;
    logic        next_counter_run_bit;
    logic [1:0]  evt_status;
    logic [1:0]  next_evt_status;
    logic [1:0]  evt_mask;
    logic [1:0]  next_evt_mask;
    logic        pin_level;
    logic        next_pin_level;
    logic        next_pin_oe_b;
    logic        next_irq;
    logic [7:0]  next_rd_data;

    logic        tick;
    logic        rise;
    logic        fall;
    logic        dec_en;
    logic        uf_ev;
    logic        cap_ev;
    logic        cnt_wr;
    logic [1:0]  evt_set;
    logic [7:0]  primary_control_reg;

    assign primary_control_reg = {mode, counter_run_bit, 4'h0};

    // ==========================================================
    // cycle prescaler and pin edges
    always_comb begin
        tick          = (presc == SBTRC_TC_LAST);
        next_presc    = tick ? SBTRC_PRESC_RST : presc + 4'h1;   // RQ12
        next_pin_prev = timer_io_pin_in;
        rise          = timer_io_pin_in & ~pin_prev;
        fall          = ~timer_io_pin_in & pin_prev;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            presc    <= SBTRC_PRESC_RST;
            pin_prev <= SBTRC_PIN_RST;
        end else if (ce) begin
            presc    <= next_presc;
            pin_prev <= next_pin_prev;
        end
    end

    // ==========================================================
    // counter, reload/capture register, control
    always_comb begin
        // a stopped counter sees no tick, edge or event
        if (!counter_run_bit) begin
            dec_en = 1'b0;                                       // RQ13
        end else if (is_tc_mode(mode)) begin
            dec_en = tick;                                       // RQ4
        end else begin
            dec_en = edge_hit(mode, rise, fall);                 // RQ7
        end
        // capture mode wraps freely instead of reloading
        uf_ev  = dec_en && !is_cap_mode(mode)
                 && (main_down_counter == 16'h0000);
        cap_ev = counter_run_bit && is_cap_mode(mode)
                 && edge_hit(mode, rise, fall);                  // RQ9
        cnt_wr = reg_wr(addr, wr_stb, SBTRC_OFS_CNT_LO)
                 || reg_wr(addr, wr_stb, SBTRC_OFS_CNT_HI);

        next_main_down_counter = main_down_counter;
        if (reg_wr(addr, wr_stb, SBTRC_OFS_CNT_LO)) begin
            next_main_down_counter[7:0] = wr_data;               // RQ1
        end else if (reg_wr(addr, wr_stb, SBTRC_OFS_CNT_HI)) begin
            next_main_down_counter[15:8] = wr_data;              // RQ1
        end else if (uf_ev) begin
            next_main_down_counter = reload_capture_reg;         // RQ4
        end else if (dec_en) begin
            next_main_down_counter = main_down_counter - 16'h0001;
        end

        // a capture beats a software write in the same cycle
        next_reload_capture_reg = reload_capture_reg;
        if (cap_ev) begin
            next_reload_capture_reg = main_down_counter;         // RQ8
        end else if (reg_wr(addr, wr_stb, SBTRC_OFS_RLD_LO)) begin
            next_reload_capture_reg[7:0] = wr_data;              // RQ1
        end else if (reg_wr(addr, wr_stb, SBTRC_OFS_RLD_HI)) begin
            next_reload_capture_reg[15:8] = wr_data;             // RQ1
        end

        next_mode            = mode;
        next_counter_run_bit = counter_run_bit;
        if (reg_wr(addr, wr_stb, SBTRC_OFS_CTRL)) begin
            next_counter_run_bit = wr_data[SBTRC_CTRL_RUN];      // RQ3
            // barred codes leave the old mode in place
            if (wr_data[SBTRC_CTRL_MODE_HI:SBTRC_CTRL_MODE_LO]
                    != SBTRC_MODE_BAD_A
                && wr_data[SBTRC_CTRL_MODE_HI:SBTRC_CTRL_MODE_LO]
                    != SBTRC_MODE_BAD_B) begin
                next_mode =
                    wr_data[SBTRC_CTRL_MODE_HI:SBTRC_CTRL_MODE_LO]; // RQ2
            end
        end

        // underflow toggle beats a software write of the level
        next_pin_level = pin_level;
        if (uf_ev && mode == SBTRC_MODE_TOGGLE) begin
            next_pin_level = ~pin_level;                         // RQ6
        end else if (reg_wr(addr, wr_stb, SBTRC_OFS_PIN)) begin
            next_pin_level = wr_data[SBTRC_PIN_LEVEL];           // RQ10
        end
        next_pin_oe_b = (next_mode != SBTRC_MODE_TOGGLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            main_down_counter  <= SBTRC_CNT_RST;
            reload_capture_reg <= SBTRC_RLD_RST;
            mode               <= SBTRC_MODE_RST;
            counter_run_bit    <= SBTRC_RUN_RST;
            pin_level          <= SBTRC_PIN_RST;
            timer_io_pin_out   <= SBTRC_PIN_RST;
            timer_io_pin_oe_b  <= 1'b1;
        end else if (ce) begin
            main_down_counter  <= next_main_down_counter;
            reload_capture_reg <= next_reload_capture_reg;
            mode               <= next_mode;
            counter_run_bit    <= next_counter_run_bit;
            pin_level          <= next_pin_level;
            timer_io_pin_out   <= next_pin_level;
            timer_io_pin_oe_b  <= next_pin_oe_b;
        end
    end

    // ==========================================================
    // interrupt status, mask and output
    assign evt_set[SBTRC_STAT_UF]  = uf_ev;                      // RQ5
    assign evt_set[SBTRC_STAT_CAP] = cap_ev;                     // RQ9

    // a new event in the clearing cycle keeps its bit set
    genvar gi;
    generate
        for (gi = 0; gi < SBTRC_NUM_EVT; gi++) begin : g_evt
            assign next_evt_status[gi] = evt_set[gi]
                || (evt_status[gi]
                    && !(reg_wr(addr, wr_stb, SBTRC_OFS_STATUS)
                         && wr_data[gi]));
        end
    endgenerate

    always_comb begin
        next_evt_mask = evt_mask;
        if (reg_wr(addr, wr_stb, SBTRC_OFS_MASK)) begin
            next_evt_mask = wr_data[1:0];
        end
        next_irq = |(next_evt_status & next_evt_mask);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            evt_status <= SBTRC_EVT_RST;
            evt_mask   <= SBTRC_EVT_RST;
            irq        <= 1'b0;
        end else if (ce) begin
            evt_status <= next_evt_status;
            evt_mask   <= next_evt_mask;
            irq        <= next_irq;
        end
    end

    // ==========================================================
    // read port: data valid for one cycle after the strobe
    always_comb begin
        next_rd_data = 8'h00;
        if (rd_stb) begin
            if (addr == SBTRC_OFS_CNT_LO) begin
                next_rd_data = main_down_counter[7:0];           // RQ1
            end else if (addr == SBTRC_OFS_CNT_HI) begin
                next_rd_data = main_down_counter[15:8];
            end else if (addr == SBTRC_OFS_RLD_LO) begin
                next_rd_data = reload_capture_reg[7:0];
            end else if (addr == SBTRC_OFS_RLD_HI) begin
                next_rd_data = reload_capture_reg[15:8];
            end else if (addr == SBTRC_OFS_CTRL) begin
                next_rd_data = primary_control_reg;
            end else if (addr == SBTRC_OFS_STATUS) begin
                next_rd_data = {6'h00, evt_status};
            end else if (addr == SBTRC_OFS_MASK) begin
                next_rd_data = {6'h00, evt_mask};
            end else begin
                next_rd_data = {6'h00, timer_io_pin_in, pin_level};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_underflow;
        ce && uf_ev && !cnt_wr;
    endsequence

    sequence s_capture;
        ce && cap_ev;
    endsequence

    sequence s_irq_cause;
        ce && (uf_ev || cap_ev);
    endsequence

    a_mode_legal: assert property (                              // RQ2
        mode != SBTRC_MODE_BAD_A && mode != SBTRC_MODE_BAD_B)
        else $error("barred mode code reached the mode field");

    a_div_wrap: assert property (                                // RQ12
        ce && presc == SBTRC_TC_LAST |=> presc == SBTRC_PRESC_RST
            && (!is_tc_mode(mode) || !dec_en))
        else $error("prescaler did not wrap after ten cycles");

    a_div_range: assert property (                               // RQ12
        presc <= SBTRC_TC_LAST)
        else $error("prescaler left its range");

    a_stop_hold: assert property (                               // RQ13
        ce && !counter_run_bit && !cnt_wr
        |=> main_down_counter == $past(main_down_counter)
            && !$past(uf_ev) && !$past(cap_ev))
        else $error("stopped counter moved");

    a_reload_uf: assert property (                               // RQ4
        s_underflow |=> main_down_counter == $past(reload_capture_reg))
        else $error("underflow did not reload the counter");

    a_tc_decr: assert property (                                 // RQ4
        ce && counter_run_bit && is_tc_mode(mode) && tick && !cnt_wr
        && !uf_ev |=> main_down_counter
            == $past(main_down_counter) - 16'h0001)
        else $error("timer mode did not count the cycle");

    a_evt_decr: assert property (                                // RQ7
        ce && counter_run_bit && !is_tc_mode(mode) && !cnt_wr && !uf_ev
        && edge_hit(mode, rise, fall)
        |=> main_down_counter == $past(main_down_counter) - 16'h0001)
        else $error("event mode missed a pin edge");

    a_pin_toggle: assert property (                              // RQ6
        s_underflow ##0 (mode == SBTRC_MODE_TOGGLE)
        |=> timer_io_pin_out != $past(timer_io_pin_out)
            && timer_io_pin_oe_b == (mode != SBTRC_MODE_TOGGLE))
        else $error("pin did not invert on underflow");

    a_capture_copy: assert property (                            // RQ8
        s_capture |=> reload_capture_reg == $past(main_down_counter))
        else $error("capture edge did not copy the counter");

    a_irq_raise: assert property (                               // RQ5
        s_irq_cause ##0 (evt_mask != 2'h0) ##1 (ce && evt_mask != 2'h0)
        |-> (evt_status != 2'h0) ##1 (!ce || irq))
        else $error("event did not reach the interrupt output");

    a_rd_count: assert property (                                // RQ1
        ce && rd_stb && addr == SBTRC_OFS_CNT_HI
        |=> rd_data == $past(main_down_counter[15:8]))
        else $error("counter high byte read wrong");

endmodule // sbtrc_timer

`default_nettype wire

// File: test/sbtrc_pin_src.sv
/*
 * Outside source on the timer pin, with a prompt or a slow answer.
 * Assumes bench requests change just after a rising edge of clk.
 */
`default_nettype none

module sbtrc_pin_src (
    // clock
    input  wire logic clk,
    // bench requests
    input  wire logic req,
    input  wire logic slow,
    // device side of the pin
    input  wire logic pin_out,
    input  wire logic pin_oe_b,
    output wire logic pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic stage = 1'b0;
    logic level = 1'b0;

    // ==========================================================
    // source
    // slow source lags one extra cycle, still one change per step
    always @(posedge clk) begin
        stage <= req;
        level <= slow ? stage : req;
    end

    // source steps aside while the timer drives the pin
    assign pin_in = pin_oe_b ? level : pin_out;

endmodule // sbtrc_pin_src

`default_nettype wire

// File: test/sbtrc_timer_tb_top.sv
/*
 * Self-checking bench for the reload/capture timer.
 * Assumes the pin source model and the timer package are compiled first.
 */
`default_nettype none

module sbtrc_timer_tb_top
    import sbtrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [7:0] v; logic [7:0] m;} sbtrc_exp_type;
    sbtrc_exp_type q[$];
    int            tq[$];
    logic          clk;
    logic          rst_b = 1'b0;
    logic          ce = 1'b1;
    logic [2:0]    addr = 3'h0;
    logic [7:0]    wr_data = 8'h00;
    logic          wr_stb = 1'b0;
    logic          rd_stb = 1'b0;
    logic          req = 1'b0;
    logic          slow = 1'b0;
    logic [7:0]    rd_data;
    logic          pin_in, pin_out, pin_oe_b, irq;
    logic          pend = 1'b0;
    logic          armed = 1'b0;
    logic          last = 1'b0;
    logic [2:0]    mode;
    logic [7:0]    v[4];
    sbtrc_exp_type e;
    int            cyc = 0;
    int            t0 = 0;
    int            miscompares = 0;
    int            checks = 0;
    integer        seed = 32'h9d7c8d7e;

    sbtrc_timer dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .timer_io_pin_in(pin_in),
        .timer_io_pin_out(pin_out), .timer_io_pin_oe_b(pin_oe_b), .irq(irq));
    sbtrc_pin_src src_u (.clk(clk), .req(req), .slow(slow),
        .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_in(pin_in));

    // ==========================================================
    // checking
    task automatic cmp8(input logic [7:0] g, x, m);
        checks++;
        if ((g & m) !== (x & m)) begin
            miscompares++;
            $display("FAIL %0t read %h want %h", $time, g, x);
        end
    endtask
    task automatic cmp1(input logic g, x);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("FAIL %0t flag %b want %b", $time, g, x);
        end
    endtask
    task automatic cmp16(input logic [15:0] g, x);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("FAIL %0t period %0d want %0d", $time, g, x);
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // cycle count read with old value everywhere, so no race
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    always @(posedge clk) begin
        if (pend && q.size() > 0) begin
            e = q.pop_front();
            cmp8(rd_data, e.v, e.m);
        end
        pend <= rd_stb;
    end
    // first toggle after arming has an unknown phase: not compared
    always @(posedge clk) begin
        if (pin_oe_b !== 1'b0)
            armed = 1'b0;
        else if (pin_out !== last) begin
            if (armed && tq.size() > 0)
                cmp16(16'(cyc - t0), 16'(tq.pop_front()));
            armed = 1'b1;
            t0 = cyc;
        end
        last = pin_out;
    end

    // ==========================================================
    // drivers
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x, m);
        q.push_back({x, m});
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic set_pin(input logic l);
        req <= l;
        slow <= 1'($random(seed));
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_irq(input logic l);
        int n;
        n = 0;
        while (irq !== l && n < 400) begin
            @(posedge clk);
            n++;
        end
        cmp1(irq, l);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        cmp1(pin_oe_b, 1'b1);
        cmp1(irq, 1'b0);
        for (int i = 0; i < 8; i++)
            rd(3'(i), 8'h00, 8'hff);
        // a write while the enable is low must be ignored
        ce <= 1'b0;
        wr(SBTRC_OFS_CNT_LO, 8'h5a);
        ce <= 1'b1;
        rd(SBTRC_OFS_CNT_LO, 8'h00, 8'hff);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            v[i] = 8'($random(seed));
            wr(3'(i), v[i]);
        end
        wr(SBTRC_OFS_CTRL, 8'h80);
        repeat (40) @(posedge clk);
        for (int i = 0; i < 4; i++)
            rd(3'(i), v[i], 8'hff);
        $display("halves done");
        mode = 3'h4;
        for (int c = 0; c < 8; c++) begin
            if (c != 2 && c != 3)
                mode = 3'(c);
            wr(SBTRC_OFS_CTRL, {3'(c), 5'h00});
            rd(SBTRC_OFS_CTRL, {mode, 5'h00}, 8'hff);
            cmp1(pin_oe_b, mode != 3'h5);
        end
        $display("modes done");
        wr(SBTRC_OFS_CTRL, 8'h80);
        wr(SBTRC_OFS_PIN, 8'h01);
        for (int i = 0; i < 4; i++)
            wr(3'(i), (i == 2) ? 8'h03 : 8'h00);
        wr(SBTRC_OFS_STATUS, 8'h03);
        wr(SBTRC_OFS_MASK, 8'h01);
        tq = '{40, 60, 40};
        wr(SBTRC_OFS_CTRL, 8'hb0);
        cmp1(pin_oe_b, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wait_irq(1'b1);
            wr(SBTRC_OFS_RLD_LO, k[0] ? 8'h03 : 8'h05);
            wr(SBTRC_OFS_STATUS, 8'h01);
            wait_irq(1'b0);
        end
        wr(SBTRC_OFS_MASK, 8'h00);
        repeat (70) @(posedge clk);
        cmp1(irq, 1'b0);
        rd(SBTRC_OFS_STATUS, 8'h01, 8'h03);
        $display("toggle timer done");
        wr(SBTRC_OFS_MASK, 8'h01);
        for (int m = 0; m < 2; m++) begin
            wr(SBTRC_OFS_CTRL, 8'h00);
            set_pin(1'b0);
            v[0] = 8'($random(seed));
            for (int i = 0; i < 4; i++)
                wr(3'(i), i == 0 ? 8'h02 : i == 2 ? v[0] : {7'h0, i[1]});
            wr(SBTRC_OFS_STATUS, 8'h03);
            wr(SBTRC_OFS_CTRL, {3'(m), 5'h10});
            set_pin(1'b1);
            rd(SBTRC_OFS_CNT_LO, m == 0 ? 8'h01 : 8'h02, 8'hff);
            set_pin(1'b0);
            rd(SBTRC_OFS_CNT_LO, 8'h01, 8'hff);
            repeat (2) begin
                set_pin(1'b1);
                set_pin(1'b0);
            end
            rd(SBTRC_OFS_CNT_LO, v[0], 8'hff);
            rd(SBTRC_OFS_CNT_HI, 8'h01, 8'hff);
            wait_irq(1'b1);
        end
        $display("event counter done");
        wr(SBTRC_OFS_MASK, 8'h02);
        for (int m = 0; m < 2; m++) begin
            wr(SBTRC_OFS_CTRL, 8'(m) << 5);
            wr(SBTRC_OFS_CNT_HI, 8'h10);
            wr(SBTRC_OFS_CNT_LO, 8'h00);
            wr(SBTRC_OFS_RLD_HI, 8'hab);
            set_pin(m == 0);
            wr(SBTRC_OFS_STATUS, 8'h03);
            rd(SBTRC_OFS_CNT_HI, 8'h10, 8'hff);
            wr(SBTRC_OFS_CTRL, {3'(6 + m), 5'h10});
            set_pin(m != 0);
            rd(SBTRC_OFS_RLD_HI, 8'hab, 8'hff);
            rd(SBTRC_OFS_STATUS, 8'h00, 8'h03);
            set_pin(m == 0);
            rd(SBTRC_OFS_STATUS, 8'h02, 8'h03);
            cmp1(irq, 1'b1);
            rd(SBTRC_OFS_RLD_HI, 8'h0f, 8'hff);
        end
        $display("capture done");
        conclude();
    end

endmodule // sbtrc_timer_tb_top

`default_nettype wire
